// ### xpl_defines.svh
`ifndef XPL_DEFINES_SVH
`define XPL_DEFINES_SVH

// Shift register geometry
`define XPL_SR_BITS 80
`define XPL_PAD_BITS 40
`define XPL_OUTPUTS 8
`define XPL_FIELD_BITS 5
`define XPL_INDEX_BITS 3
`define XPL_SRC_BITS 4

// Bit positions inside one output slot, counted from the slot base
`define XPL_POS_ENABLE 0
`define XPL_POS_SRC_MSB 1
`define XPL_POS_SRC_LSB 4

// Reset values
`define XPL_SR_RESET 80'h0
`define XPL_MATRIX_RESET 40'h0
`define XPL_PIN_RESET 14'h1C00

// Synchroniser depth, in flip-flops
`define XPL_SYNC_STAGES 2

`endif

// ### xpl_pkg.sv
package xpl_pkg;

    // One output's programming: source select and enable bit
    typedef struct packed {
        logic enable;
        logic [3:0] source;
    } xpl_field_s;

    // Host-side pins, as seen after synchronisation
    typedef struct packed {
        logic disable_all_n;
        logic shift_clk;
        logic chip_sel_n;
        logic update_n;
        logic load_mode_sel;
        logic serial_in;
        logic [2:0] output_index;
        logic [4:0] par_data;
    } xpl_pins_s;

    typedef enum logic {
        XPL_SERIAL = 1'b0,
        XPL_PARALLEL = 1'b1
    } xpl_mode_e;

endpackage : xpl_pkg

// ### xpl_sync.sv
`timescale 1ns/1ns
`include "xpl_defines.svh"

module xpl_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic ce,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;

    // First stage feeds only the second
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_r <= RST_VAL;
            q_r <= RST_VAL;
        end else if (ce) begin
            meta_r <= d;
            q_r <= meta_r;
        end
    end

    assign q = q_r;

endmodule : xpl_sync

// ### xpl_loader.sv
// Functional notes
// - One 80-bit serial word reprograms every output in one load.
// - Mode select low picks serial loading, high picks parallel loading.
// - Clocked data is accepted only while chip select is low.
// - Update latch is transparent while update and chip select are low.
// - Serial input shifts in on each falling shift clock edge.
// - Each field is 4-bit source then enable; disabled ignores source.
// - Taking update low after shifting programs the matrix.
// - Parallel falling clock writes addressed slot, matrix unchanged while update is high.
// - Several parallel loads under high update take effect together.
// - Disable pin forces all outputs off, keeps register and sources.
// - Loads go to a first rank; a second rank updates all at once.
`timescale 1ns/1ns
`include "xpl_defines.svh"

module xpl_loader (
    // Clock, reset, clock enable
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic ce,
    // Host control pins
    input wire logic shift_clk,
    input wire logic chip_sel_n,
    input wire logic update_n,
    input wire logic load_mode_sel,
    input wire logic disable_all_n,
    // Host data pins
    input wire logic serial_in,
    input wire logic [2:0] output_index,
    input wire logic [4:0] par_data,
    // Daisy chain
    output logic serial_out,
    // Switch matrix programming
    output xpl_pkg::xpl_field_s [7:0] matrix
);

    localparam int PIN_W = $bits(xpl_pkg::xpl_pins_s);

    // Slot k occupies bits 5k+4 (first shifted) down to 5k (enable)
    function automatic xpl_pkg::xpl_field_s xpl_slot(
        input logic [`XPL_SR_BITS-1:0] sr,
        input logic [`XPL_INDEX_BITS-1:0] idx
    );
        logic [`XPL_FIELD_BITS-1:0] b;
        b = sr[idx*`XPL_FIELD_BITS +: `XPL_FIELD_BITS];
        xpl_slot.enable = b[`XPL_POS_ENABLE];
        xpl_slot.source = {b[`XPL_POS_SRC_MSB], b[2], b[3],
                           b[`XPL_POS_SRC_LSB]};
    endfunction : xpl_slot

    function automatic logic [`XPL_FIELD_BITS-1:0] xpl_pack(
        input xpl_pkg::xpl_field_s f
    );
        xpl_pack = {f.source[0], f.source[1], f.source[2], f.source[3],
                    f.enable};
    endfunction : xpl_pack

    // Marks one slot, for the parallel write check
    function automatic logic [`XPL_SR_BITS-1:0] xpl_slot_mask(
        input logic [`XPL_INDEX_BITS-1:0] idx
    );
        xpl_slot_mask = '0;
        xpl_slot_mask[idx*`XPL_FIELD_BITS +: `XPL_FIELD_BITS] = '1;
    endfunction : xpl_slot_mask

    // Every pin is asynchronous to sys_clk
    xpl_pkg::xpl_pins_s pins_raw;
    xpl_pkg::xpl_pins_s pins_s;

    assign pins_raw.disable_all_n = disable_all_n;
    assign pins_raw.shift_clk = shift_clk;
    assign pins_raw.chip_sel_n = chip_sel_n;
    assign pins_raw.update_n = update_n;
    assign pins_raw.load_mode_sel = load_mode_sel;
    assign pins_raw.serial_in = serial_in;
    assign pins_raw.output_index = output_index;
    assign pins_raw.par_data = par_data;

    xpl_sync #(
        .W(PIN_W),
        .RST_VAL(`XPL_PIN_RESET)
    ) u_pin_sync (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .ce(ce),
        .d(pins_raw),
        .q(pins_s)
    );

    // State
    logic clk_d_r;
    logic [`XPL_SR_BITS-1:0] sr_r;
    logic [`XPL_SR_BITS-1:0] sr_nxt;
    xpl_pkg::xpl_field_s [7:0] matrix_r;
    xpl_pkg::xpl_field_s [7:0] matrix_nxt;

    // Decode
    wire clk_fall = clk_d_r & ~pins_s.shift_clk;
    wire selected = ~pins_s.chip_sel_n;
    wire xpl_pkg::xpl_mode_e mode = xpl_pkg::xpl_mode_e'(pins_s.load_mode_sel);
    wire ser_fire = clk_fall & selected & (mode == xpl_pkg::XPL_SERIAL);
    wire par_fire = clk_fall & selected & (mode == xpl_pkg::XPL_PARALLEL);
    wire transparent = selected & ~pins_s.update_n;
    wire disable_all = ~pins_s.disable_all_n;
    wire [`XPL_INDEX_BITS-1:0] par_idx = pins_s.output_index;
    wire xpl_pkg::xpl_field_s par_field = '{
        enable: pins_s.par_data[4],
        source: pins_s.par_data[3:0]
    };

    // First rank: serial shift or one parallel slot
    wire [`XPL_SR_BITS-1:0] sr_shifted = {sr_r[`XPL_SR_BITS-2:0],
                                          pins_s.serial_in};

    always_comb begin
        sr_nxt = sr_r;
        if (ser_fire) begin
            sr_nxt = sr_shifted;
        end else if (par_fire) begin
            sr_nxt[par_idx*`XPL_FIELD_BITS +: `XPL_FIELD_BITS] =
                xpl_pack(par_field);
        end
    end

    // Second rank: all outputs move together
    xpl_pkg::xpl_field_s [7:0] sr_view;
    logic [7:0] en_vec;
    logic [31:0] src_vec;
    logic [7:0] sr_en_vec;
    logic [31:0] sr_src_vec;

    genvar k;
    generate
        for (k = 0; k < `XPL_OUTPUTS; k = k + 1) begin : g_out
            assign sr_view[k] = xpl_slot(sr_r, 3'(k));
            // Disable pin wins over a transparent latch
            assign matrix_nxt[k].enable = disable_all ? 1'b0 :
                transparent ? sr_view[k].enable :
                matrix_r[k].enable;
            assign matrix_nxt[k].source = transparent ?
                sr_view[k].source : matrix_r[k].source;
            assign en_vec[k] = matrix_r[k].enable;
            assign src_vec[k*4 +: 4] = matrix_r[k].source;
            assign sr_en_vec[k] = sr_view[k].enable;
            assign sr_src_vec[k*4 +: 4] = sr_view[k].source;
        end
    endgenerate

    // Sampled pins may lag the real ones by two sys_clk cycles
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            clk_d_r <= 1'b1;
            sr_r <= `XPL_SR_RESET;
            matrix_r <= `XPL_MATRIX_RESET;
        end else if (ce) begin
            clk_d_r <= pins_s.shift_clk;
            sr_r <= sr_nxt;
            matrix_r <= matrix_nxt;
        end
    end

    assign serial_out = sr_r[`XPL_SR_BITS-1];
    assign matrix = matrix_r;

    // Checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);

    sequence s_clk_fall;
        clk_d_r && !pins_s.shift_clk;
    endsequence

    sequence s_serial_load;
        ce && selected && !pins_s.load_mode_sel ##0 s_clk_fall;
    endsequence

    sequence s_parallel_load;
        ce && selected && pins_s.load_mode_sel ##0 s_clk_fall;
    endsequence

    property p_shift;
        s_serial_load |=>
            sr_r == {$past(sr_r[`XPL_SR_BITS-2:0]), $past(pins_s.serial_in)};
    endproperty

    a_serial_shift_in: assert property (p_shift)
        else $error("serial shift did not take the input bit");

    a_deselect_blocks_load: assert property (
        ce && pins_s.chip_sel_n |=> sr_r == $past(sr_r))
        else $error("shift register changed while deselected");

    a_parallel_slot_write: assert property (
        s_parallel_load |=>
            xpl_slot(sr_r, $past(par_idx)) == $past(par_field))
        else $error("parallel load missed the addressed slot");

    a_matrix_holds_update: assert property (
        ce && !transparent && !disable_all |=> $stable(matrix_r))
        else $error("matrix changed without update");

    a_transparent_follow: assert property (
        ce && transparent && !disable_all |=> matrix_r == $past(sr_view))
        else $error("transparent latch did not follow first rank");

    a_disable_all_off: assert property (
        ce && disable_all |=> en_vec == 8'h00)
        else $error("output enabled while disable pin low");

    a_disable_keeps_src: assert property (
        ce && disable_all && !transparent |=>
            $stable(src_vec) && $stable(sr_r) || $past(ser_fire || par_fire))
        else $error("disable pin disturbed stored sources");

    a_chain_far_bit: assert property (
        s_serial_load |=> serial_out == $past(sr_r[`XPL_SR_BITS-2]))
        else $error("serial out is not the far-end bit");

    a_frozen_no_ce: assert property (
        !ce [*2] |-> $stable(sr_r) && $stable(matrix_r))
        else $error("state moved with clock enable low");

    // Update gate as seen by the second rank
    sequence s_update_open;
        ce && transparent && !disable_all;
    endsequence

    sequence s_update_shut;
        ce && !transparent && !disable_all;
    endsequence

    // First rank moves only on a detected falling edge
    a_first_rank_idle: assert property (
        ce && !clk_fall |=> $stable(sr_r))
        else $error("first rank changed without a clock fall");

    a_serial_low_end: assert property (
        s_serial_load |=> sr_r[0] == $past(pins_s.serial_in))
        else $error("serial input bit did not enter the low end");

    a_serial_hidden: assert property (
        s_serial_load ##0 s_update_shut |=> $stable(matrix_r))
        else $error("serial shift reached the matrix under closed update");

    a_parallel_keeps_rest: assert property (
        s_parallel_load |=> ((sr_r ^ $past(sr_r)) &
            ~xpl_slot_mask($past(par_idx))) == '0)
        else $error("parallel load touched another slot");

    a_parallel_hidden: assert property (
        s_parallel_load ##0 s_update_shut |=> $stable(matrix_r))
        else $error("parallel load reached the matrix under closed update");

    a_update_enables: assert property (
        s_update_open |=> en_vec == $past(sr_en_vec))
        else $error("open update did not pass the enable bits");

    a_update_sources: assert property (
        s_update_open |=> src_vec == $past(sr_src_vec))
        else $error("open update did not pass the sources");

    a_update_keeps_rank: assert property (
        s_update_open ##0 !clk_fall |=> $stable(sr_r))
        else $error("update disturbed the first rank");

    a_closed_sources: assert property (
        ce && !transparent |=> $stable(src_vec))
        else $error("sources changed under closed update");

    // Deselected device ignores both ranks' controls
    a_deselect_matrix: assert property (
        ce && pins_s.chip_sel_n && !disable_all |=> $stable(matrix_r))
        else $error("matrix changed while deselected");

    a_deselect_chain: assert property (
        ce && pins_s.chip_sel_n |=> $stable(serial_out))
        else $error("serial out moved while deselected");

    // Disable pin acts on enables only
    a_disable_rank_kept: assert property (
        ce && disable_all && !clk_fall |=> $stable(sr_r))
        else $error("disable pin disturbed the first rank");

    a_disable_src_follow: assert property (
        ce && transparent && disable_all |=> src_vec == $past(sr_src_vec))
        else $error("sources stopped following under disable");

    a_chain_idle: assert property (
        ce && !clk_fall |=> $stable(serial_out))
        else $error("serial out moved without a clock fall");

    a_frozen_pins: assert property (
        !ce [*2] |-> $stable(pins_s) && $stable(clk_d_r))
        else $error("pin samples moved with clock enable low");

endmodule : xpl_loader

// ### xpl_host.sv
`timescale 1ns/1ns
module xpl_host (
    // Clock
    input wire logic sys_clk,
    // Pins toward the loader
    output logic shift_clk,
    output logic chip_sel_n,
    output logic load_mode_sel,
    output logic serial_in,
    output logic [2:0] output_index,
    output logic [4:0] par_data
);
    initial begin
        shift_clk = 1'b1;
        chip_sel_n = 1'b1;
        load_mode_sel = 1'b0;
        serial_in = 1'b0;
        output_index = 3'h0;
        par_data = 5'h00;
    end
    // Half of the 160 ns link period
    task automatic phase();
        repeat (8) @(negedge sys_clk);
    endtask : phase
    // Clock stands high between bits
    task automatic tick();
        phase();
        shift_clk = 1'b0;
        phase();
        shift_clk = 1'b1;
    endtask : tick
    task automatic send_bit(input logic b, input logic sel_n);
        chip_sel_n = sel_n;
        load_mode_sel = 1'b0;
        serial_in = b;
        phase();
        shift_clk = 1'b0;
        // Data turns mid low phase, so a late sample would see it
        repeat (4) @(negedge sys_clk);
        serial_in = ~b;
        repeat (4) @(negedge sys_clk);
        shift_clk = 1'b1;
    endtask : send_bit
    task automatic send_word(input logic [39:0] m);
        repeat (40) send_bit(1'b0, 1'b0);
        for (int k = 7; k >= 0; k--) begin
            for (int i = 0; i < 4; i++) begin
                send_bit(m[k*5+i], 1'b0);
            end
            send_bit(m[k*5+4], 1'b0);
        end
    endtask : send_word
    task automatic par_write(input logic [2:0] idx, input logic [4:0] d);
        load_mode_sel = 1'b1;
        chip_sel_n = 1'b0;
        output_index = idx;
        par_data = d;
        tick();
    endtask : par_write
endmodule : xpl_host

// ### tb_top.sv
`timescale 1ns/1ns
module tb_top;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic ce = 1'b1;
    logic update_n = 1'b1;
    logic disable_all_n = 1'b1;
    logic shift_clk, chip_sel_n, load_mode_sel, serial_in, serial_out;
    logic [2:0] output_index;
    logic [4:0] par_data;
    xpl_pkg::xpl_field_s [7:0] matrix;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;
    logic [39:0] exp_m;
    always #5 sys_clk = ~sys_clk;
    xpl_loader u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .ce(ce),
        .shift_clk(shift_clk), .chip_sel_n(chip_sel_n),
        .update_n(update_n), .load_mode_sel(load_mode_sel),
        .disable_all_n(disable_all_n), .serial_in(serial_in),
        .output_index(output_index), .par_data(par_data),
        .serial_out(serial_out), .matrix(matrix));
    xpl_host u_host (.sys_clk(sys_clk), .shift_clk(shift_clk),
        .chip_sel_n(chip_sel_n), .load_mode_sel(load_mode_sel),
        .serial_in(serial_in), .output_index(output_index),
        .par_data(par_data));
    task automatic stop_test();
        if (num_errors == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input string name, input logic [39:0] e,
                       input logic [39:0] g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, e, g);
        end
    endtask : chk
    // Long enough for the synchronisers to pass any pin change
    task automatic settle();
        repeat (8) @(negedge sys_clk);
    endtask : settle
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 10000) begin
            num_errors++;
            stop_test();
        end
    end
    task automatic t_serial();
        exp_m = 40'hB56D3A9CE7;
        u_host.send_word(exp_m);
        settle();
        chk("matrix held", 40'h0, matrix);
        update_n = 1'b0;
        settle();
        chk("matrix serial", exp_m, matrix);
        update_n = 1'b1;
        u_host.send_bit(1'b1, 1'b1);
        repeat (40) u_host.send_bit(1'b0, 1'b0);
        settle();
        chk("serial_out", {39'h0, exp_m[35]}, {39'h0, serial_out});
        chk("matrix shifting", exp_m, matrix);
    endtask : t_serial
    task automatic t_par();
        u_host.par_write(3'h2, 5'h15);
        u_host.par_write(3'h6, 5'h0A);
        settle();
        chk("matrix par held", exp_m, matrix);
        u_host.chip_sel_n = 1'b1;
        update_n = 1'b0;
        settle();
        chk("matrix unselected", exp_m, matrix);
        exp_m = 40'h0;
        exp_m[14:10] = 5'h15;
        exp_m[34:30] = 5'h0A;
        u_host.chip_sel_n = 1'b0;
        settle();
        chk("matrix parallel", exp_m, matrix);
    endtask : t_par
    task automatic t_disable();
        exp_m = 40'h9CE75AD6B5;
        update_n = 1'b1;
        u_host.send_word(exp_m);
        update_n = 1'b0;
        disable_all_n = 1'b0;
        settle();
        chk("matrix disabled", exp_m & ~40'h8421084210, matrix);
        disable_all_n = 1'b1;
        settle();
        chk("matrix restored", exp_m, matrix);
    endtask : t_disable
    task automatic t_freeze();
        ce = 1'b0;
        u_host.send_bit(1'b1, 1'b0);
        ce = 1'b1;
        settle();
        chk("matrix frozen", exp_m, matrix);
        chk("serial_out frozen", 40'h0, {39'h0, serial_out});
    endtask : t_freeze
    initial begin
        repeat (4) @(negedge sys_clk);
        arst_n = 1'b1;
        settle();
        t_serial();
        t_par();
        t_disable();
        t_freeze();
        stop_test();
    end
endmodule : tb_top
